// File: hw/data_line_relay.v
// half-duplex relay between host and card data lines
`timescale 1ns/10ps
module data_line_relay
#(
  parameter DLY_CYC = 20,
  parameter PU_CYC  = 20
)
(
  input  wire clk,
  input  wire arst_n,
  input  wire en,
  input  wire a_in,
  input  wire b_in,
  output wire a_low,
  output wire a_high,
  output wire b_low,
  output wire b_high
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DLY  = 5'h02;
  localparam [4:0] ST_LOW  = 5'h04;
  localparam [4:0] ST_PU   = 5'h08;
  localparam [4:0] ST_WAIT = 5'h10;
  localparam [7:0] DLY_LAST = DLY_CYC[7:0] - 8'h01;
  localparam [7:0] PU_LAST  = PU_CYC[7:0] - 8'h01;

  reg [4:0] st_r;
  reg [7:0] cnt_r;
  reg       b_master_r;
  reg       a_d_r;
  reg       b_d_r;

  wire a_fall = a_d_r & ~a_in;
  wire b_fall = b_d_r & ~b_in;
  wire m_in   = b_master_r ? b_in : a_in;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r       <= ST_IDLE;
      cnt_r      <= 8'h00;
      b_master_r <= 1'b0;
      a_d_r      <= 1'b1;
      b_d_r      <= 1'b1;
    end
    else
    begin
      a_d_r <= a_in;
      b_d_r <= b_in;
      if (!en)
        st_r <= ST_IDLE;
      else
        case (st_r)
          ST_IDLE:
            // host wins a tie; the slave's edges are not looked at after
            if (a_fall || b_fall)
            begin
              b_master_r <= ~a_fall;
              cnt_r      <= 8'h00;
              st_r       <= ST_DLY;
            end
          ST_DLY:
            if (cnt_r == DLY_LAST)
              st_r <= ST_LOW;
            else
              cnt_r <= cnt_r + 8'h01;
          ST_LOW:
            if (m_in)
            begin
              cnt_r <= 8'h00;
              st_r  <= ST_PU;
            end
          ST_PU:
            if (cnt_r == PU_LAST)
              st_r <= ST_WAIT;
            else
              cnt_r <= cnt_r + 8'h01;
          ST_WAIT:
            if (a_in && b_in)
              st_r <= ST_IDLE;
          default:
            st_r <= ST_IDLE;
        endcase
    end
  end

  assign a_low  = (st_r == ST_LOW) &  b_master_r;
  assign b_low  = (st_r == ST_LOW) & ~b_master_r;
  assign a_high = (st_r == ST_PU)  &  b_master_r;
  assign b_high = (st_r == ST_PU)  & ~b_master_r;

endmodule

// File: hw/osc_timebase.v
// internal oscillator model: low and high frequency tick generators
`timescale 1ns/10ps
module osc_timebase
#(
  parameter LF_DIV = 666,
  parameter HF_DIV = 37
)
(
  input  wire clk,
  input  wire arst_n,
  input  wire restart,
  input  wire hf_en,
  output reg  lf_tick,
  output reg  hf_tick
);

  localparam [15:0] LF_LAST = LF_DIV[15:0] - 16'h0001;
  localparam [15:0] HF_LAST = HF_DIV[15:0] - 16'h0001;

  reg [15:0] lf_cnt_r;
  reg [15:0] hf_cnt_r;

  // the slow oscillator always runs; restart aligns it to a command edge
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lf_cnt_r <= 16'h0000;
      lf_tick  <= 1'b0;
    end
    else if (restart || lf_cnt_r == LF_LAST)
    begin
      lf_cnt_r <= 16'h0000;
      lf_tick  <= !restart;
    end
    else
    begin
      lf_cnt_r <= lf_cnt_r + 16'h0001;
      lf_tick  <= 1'b0;
    end
  end

  // fast mode counts from zero at the instant it is switched on
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hf_cnt_r <= 16'h0000;
      hf_tick  <= 1'b0;
    end
    else if (!hf_en || hf_cnt_r == HF_LAST)
    begin
      hf_cnt_r <= 16'h0000;
      hf_tick  <= hf_en;
    end
    else
    begin
      hf_cnt_r <= hf_cnt_r + 16'h0001;
      hf_tick  <= 1'b0;
    end
  end

endmodule

// File: hw/sc_seq_regs.vh
// timing constants and reset values of the smartcard session sequencer
`ifndef SC_SEQ_REGS_VH
`define SC_SEQ_REGS_VH

// core clock and internal oscillator rates
`define CORE_CLK_HZ      100000000
`define CLK_PERIOD_NS    10
`define OSC_LF_HZ        150000
`define OSC_HF_HZ        2700000
`define OSC_LF_DIV       (`CORE_CLK_HZ / `OSC_LF_HZ)
`define OSC_HF_DIV       (`CORE_CLK_HZ / `OSC_HF_HZ)

// sequencer counts, in oscillator periods
`define POR_HOLD_LF      1024
`define DEBOUNCE_LF      640
`define WAKE_LF          384
`define PERIOD_T_HF      64
`define IO_HIGH_HF       (17 * `PERIOD_T_HF / 2)
`define RST_EN_HF        (23 * `PERIOD_T_HF / 2)
`define DEACT_RST_HF     (3 * `PERIOD_T_HF / 64)
`define DEACT_CLK_HF     (`PERIOD_T_HF / 2)
`define DEACT_IO_HF      (`PERIOD_T_HF)
`define DEACT_VCC_HF     (3 * `PERIOD_T_HF / 2)

// data line relay timing
`define XFER_DLY_NS      200
`define PULLUP_NS        200
`define XFER_DLY_CYC     ((`XFER_DLY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULLUP_CYC       ((`PULLUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// synchroniser reset image: command, data lines and low-supply flag idle high
`define SYNC_RST_VAL     13'h0c81

`endif

// File: hw/smartcard_session_sequencer.v
// smartcard session sequencer: activation, deactivation, faults, data relay
`timescale 1ns/10ps
`include "sc_seq_regs.vh"
module smartcard_session_sequencer
#(
  parameter LF_DIV   = `OSC_LF_DIV,
  parameter HF_DIV   = `OSC_HF_DIV,
  parameter POR_HOLD = `POR_HOLD_LF,
  parameter DEBOUNCE = `DEBOUNCE_LF,
  parameter WAKE     = `WAKE_LF
)
(
  // clock and reset
  input  wire       CORE_CLK,
  input  wire       ARST_N,
  // host control
  input  wire       CARD_POWER_CMD_N,
  input  wire       HOST_RESET_IN,
  input  wire       HOST_CLK_IN,
  input  wire       VCC_SEL_5V,
  output reg        CARD_FAULT_STATUS,
  output reg        OSC_HIGH_FREQ,
  output reg        INTERNAL_POR,
  // supervisors and sensors
  input  wire       CARD_PRESENT_SWITCH,
  input  wire       SUPPLY_OVERCURRENT,
  input  wire [2:0] SUPPLY_LOW,
  input  wire       OVERHEAT,
  input  wire       CARD_SUPPLY_LOW,
  // card supply and contacts
  output reg        CARD_SUPPLY_EN,
  output reg        CARD_SUPPLY_5V,
  output reg        CARD_RST,
  output reg        CARD_CLK_OUT,
  // host data line
  input  wire       HOST_DATA_IN,
  output reg        HOST_DATA_OUT,
  output reg        HOST_DATA_OE_N,
  // card data line
  input  wire       CARD_DATA_IN,
  output reg        CARD_DATA_OUT,
  output reg        CARD_DATA_OE_N
);

  localparam [6:0] S_HOLD   = 7'h01;
  localparam [6:0] S_SHUT   = 7'h02;
  localparam [6:0] S_WAKE   = 7'h04;
  localparam [6:0] S_ACT    = 7'h08;
  localparam [6:0] S_ACTIVE = 7'h10;
  localparam [6:0] S_DEACT  = 7'h20;
  localparam [6:0] S_DISCH  = 7'h40;

  localparam [10:0] HOLD_LAST  = POR_HOLD[10:0] - 11'h001;
  localparam [10:0] DEB_LAST   = DEBOUNCE[10:0] - 11'h001;
  localparam [10:0] WAKE_LAST  = WAKE[10:0] - 11'h001;
  localparam [10:0] IO_HI      = `IO_HIGH_HF;
  localparam [10:0] RST_ON     = `RST_EN_HF;
  localparam [10:0] D_RST      = `DEACT_RST_HF;
  localparam [10:0] D_CLK      = D_RST + `DEACT_CLK_HF;
  localparam [10:0] D_IO       = D_RST + `DEACT_IO_HF;
  localparam [10:0] D_VCC      = D_RST + `DEACT_VCC_HF;
  localparam [10:0] ONE        = 11'h001;
  localparam [12:0] SYNC_INIT  = `SYNC_RST_VAL;

  // two-stage synchronisers for every pin input
  wire [12:0] async_in = {VCC_SEL_5V, CARD_DATA_IN, HOST_DATA_IN,
                          HOST_CLK_IN, HOST_RESET_IN, CARD_SUPPLY_LOW,
                          OVERHEAT, SUPPLY_LOW, SUPPLY_OVERCURRENT,
                          CARD_PRESENT_SWITCH, CARD_POWER_CMD_N};
  wire [12:0] sync;

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1)
    begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge CORE_CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          meta_r <= SYNC_INIT[gi];
          sync_r <= SYNC_INIT[gi];
        end
        else
        begin
          meta_r <= async_in[gi];
          sync_r <= meta_r;
        end
      end
      assign sync[gi] = sync_r;
    end
  endgenerate

  wire       cmd_n_s   = sync[0];
  wire       card_present_switch_s    = sync[1];
  wire       ovc_s     = sync[2];
  wire [2:0] sup_low_s = sync[5:3];
  wire       heat_s    = sync[6];
  wire       vcc_low_s = sync[7];
  wire       rst_in_s  = sync[8];
  wire       clk_in_s  = sync[9];
  wire       host_io_s = sync[10];
  wire       card_io_s = sync[11];
  wire       vsel_s    = sync[12];

  reg  [6:0]  state_r;
  reg  [10:0] cnt_r;
  reg  [10:0] deb_cnt_r;
  reg         deb_r;
  reg         cmd_d_r;
  reg         io_on_r;
  reg         kick_r;
  reg         clk_on_r;
  reg         rst_en_r;
  reg         supply_r;

  wire lf_tick;
  wire hf_tick;
  wire a_low;
  wire a_high;
  wire b_low;
  wire b_high;

  wire sup_ok   = ~|sup_low_s;
  wire cmd_fall = cmd_d_r & ~cmd_n_s;
  wire in_sess  = |(state_r & (S_WAKE | S_ACT | S_ACTIVE));
  // removal acts on the raw synced level, so no debounce delay here
  wire fault    = ovc_s | ~card_present_switch_s | ~sup_ok | heat_s;
  wire stop     = cmd_n_s | fault;
  // fast mode from the switch, or from a stop during wake-up, until deactivation completes
  wire hf_en    = |(state_r & (S_ACT | S_ACTIVE | S_DEACT | S_DISCH));
  wire relay_en = io_on_r & ~kick_r;

  osc_timebase
  #(
    .LF_DIV (LF_DIV),
    .HF_DIV (HF_DIV)
  )
  u_osc
  (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .restart (cmd_fall & state_r[1]),
    .hf_en   (hf_en),
    .lf_tick (lf_tick),
    .hf_tick (hf_tick)
  );

  data_line_relay
  #(
    .DLY_CYC (`XFER_DLY_CYC),
    .PU_CYC  (`PULLUP_CYC)
  )
  u_relay
  (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .en     (relay_en),
    .a_in   (host_io_s),
    .b_in   (card_io_s),
    .a_low  (a_low),
    .a_high (a_high),
    .b_low  (b_low),
    .b_high (b_high)
  );

  // insertion waits out the bounce; removal clears at once
  always @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      deb_r     <= 1'b0;
      deb_cnt_r <= 11'h000;
    end
    else if (!card_present_switch_s)
    begin
      deb_r     <= 1'b0;
      deb_cnt_r <= 11'h000;
    end
    else if (!deb_r && lf_tick)
    begin
      if (deb_cnt_r == DEB_LAST)
        deb_r <= 1'b1;
      else
        deb_cnt_r <= deb_cnt_r + ONE;
    end
  end

  // main sequencer
  always @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r  <= S_HOLD;
      cnt_r    <= 11'h000;
      cmd_d_r  <= 1'b1;
      io_on_r  <= 1'b0;
      kick_r   <= 1'b0;
      clk_on_r <= 1'b0;
      rst_en_r <= 1'b0;
      supply_r <= 1'b0;
    end
    else
    begin
      cmd_d_r <= cmd_n_s;
      case (state_r)
        S_HOLD:
          if (!sup_ok)
            cnt_r <= 11'h000;
          else if (lf_tick)
          begin
            if (cnt_r == HOLD_LAST)
              state_r <= S_SHUT;
            else
              cnt_r <= cnt_r + ONE;
          end
        S_SHUT:
          if (!sup_ok)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_HOLD;
          end
          else if (cmd_fall)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_WAKE;
          end
        S_WAKE:
          if (stop)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_DEACT;
          end
          else if (lf_tick)
          begin
            if (cnt_r == WAKE_LAST)
            begin
              cnt_r    <= 11'h000;
              supply_r <= 1'b1;
              state_r  <= S_ACT;
            end
            else
              cnt_r <= cnt_r + ONE;
          end
        S_ACT:
          if (stop)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_DEACT;
          end
          else if (hf_tick)
          begin
            cnt_r <= cnt_r + ONE;
            if (cnt_r == IO_HI - ONE)
            begin
              io_on_r <= 1'b1;
              kick_r  <= 1'b1;
            end
            // clock lands one fast period after the data line rises
            if (cnt_r == IO_HI)
            begin
              kick_r   <= 1'b0;
              clk_on_r <= 1'b1;
            end
            if (cnt_r == RST_ON - ONE)
            begin
              rst_en_r <= 1'b1;
              state_r  <= S_ACTIVE;
            end
          end
        S_ACTIVE:
          if (stop)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_DEACT;
          end
        S_DEACT:
          if (hf_tick)
          begin
            cnt_r <= cnt_r + ONE;
            if (cnt_r == D_RST - ONE)
              rst_en_r <= 1'b0;
            if (cnt_r == D_CLK - ONE)
              clk_on_r <= 1'b0;
            if (cnt_r == D_IO - ONE)
            begin
              io_on_r <= 1'b0;
              kick_r  <= 1'b0;
            end
            if (cnt_r == D_VCC - ONE)
            begin
              supply_r <= 1'b0;
              state_r  <= S_DISCH;
            end
          end
        S_DISCH:
          if (vcc_low_s)
          begin
            cnt_r   <= 11'h000;
            state_r <= S_SHUT;
          end
        default:
          state_r <= S_HOLD;
      endcase
    end
  end

  // output registers; contacts rest low outside the powered window
  always @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CARD_FAULT_STATUS <= 1'b0;
      OSC_HIGH_FREQ     <= 1'b0;
      INTERNAL_POR      <= 1'b1;
      CARD_SUPPLY_EN    <= 1'b0;
      CARD_SUPPLY_5V    <= 1'b0;
      CARD_RST          <= 1'b0;
      CARD_CLK_OUT      <= 1'b0;
      HOST_DATA_OUT     <= 1'b1;
      HOST_DATA_OE_N    <= 1'b1;
      CARD_DATA_OUT     <= 1'b0;
      CARD_DATA_OE_N    <= 1'b0;
    end
    else
    begin
      if (in_sess && fault)
        CARD_FAULT_STATUS <= 1'b0;
      else if (state_r == S_SHUT)
        CARD_FAULT_STATUS <= deb_r;
      OSC_HIGH_FREQ  <= hf_en;
      INTERNAL_POR   <= (state_r == S_HOLD);
      CARD_SUPPLY_EN <= supply_r;
      // level chosen when the wake-up begins and held for the session
      if (state_r == S_SHUT)
        CARD_SUPPLY_5V <= vsel_s;
      CARD_RST       <= rst_en_r & rst_in_s;
      // the host owns the clock edges; this only gates them
      CARD_CLK_OUT   <= clk_on_r & clk_in_s;
      HOST_DATA_OUT  <= a_high;
      HOST_DATA_OE_N <= ~(a_low | a_high);
      if (!io_on_r)
      begin
        CARD_DATA_OUT  <= 1'b0;
        CARD_DATA_OE_N <= 1'b0;
      end
      else
      begin
        CARD_DATA_OUT  <= kick_r | b_high;
        CARD_DATA_OE_N <= ~(kick_r | b_low | b_high);
      end
    end
  end

endmodule

// File: sim/sc_partner.sv
// host and card model: pulled-up data lines, card supply, external clock
`timescale 1ns/10ps
module sc_partner
(
  input  wire clk,
  input  wire supply_en,
  input  wire host_oe_n,
  input  wire host_out,
  input  wire card_oe_n,
  input  wire card_out,
  input  wire host_pull,
  input  wire card_pull,
  output wire host_line,
  output wire card_line,
  output reg  card_supply_low,
  output reg  ext_clk
);
  reg [5:0] lvl_r;
  // released lines float high through the pull-ups; any low driver wins
  assign host_line = !(host_pull || (!host_oe_n && !host_out));
  assign card_line = !(card_pull || (!card_oe_n && !card_out));
  initial
  begin
    lvl_r = 6'h0;
    card_supply_low = 1'b1;
    ext_clk = 1'b0;
    #7;
    forever #80 ext_clk = ~ext_clk;
  end
  // supply level ramps both ways, so the low flag lags the enable
  always @(posedge clk)
  begin
    if (supply_en && lvl_r < 6'h28)
      lvl_r <= lvl_r + 6'h1;
    else if (!supply_en && lvl_r != 6'h0)
      lvl_r <= lvl_r - 6'h1;
    card_supply_low <= lvl_r < 6'h08;
  end
endmodule

// File: sim/sc_seq_checker.sv
// port assertions for the smartcard session sequencer
`timescale 1ns/10ps
module sc_seq_checker
#(
  parameter HF_DIV = 37
)
(
  input wire CORE_CLK,
  input wire ARST_N,
  input wire CARD_POWER_CMD_N,
  input wire CARD_PRESENT_SWITCH,
  input wire OVERHEAT,
  input wire CARD_DATA_IN,
  input wire CARD_FAULT_STATUS,
  input wire OSC_HIGH_FREQ,
  input wire INTERNAL_POR,
  input wire CARD_SUPPLY_EN,
  input wire CARD_RST,
  input wire CARD_CLK_OUT,
  input wire HOST_DATA_OUT,
  input wire HOST_DATA_OE_N,
  input wire CARD_DATA_OUT,
  input wire CARD_DATA_OE_N
);
  localparam int DATA_AT = 544 * HF_DIV;
  localparam int RST_AT  = 736 * HF_DIV;
  reg [15:0] act_r;
  reg        seen_r;
  // cycles in fast mode, and whether card data went high this session
  always @(posedge CORE_CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      act_r  <= 16'h0;
      seen_r <= 1'b0;
    end
    else
    begin
      act_r  <= OSC_HIGH_FREQ ? act_r + 16'h1 : 16'h0;
      seen_r <= OSC_HIGH_FREQ && (seen_r || CARD_DATA_OUT);
    end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  chk_por_quiet: assert property (
    INTERNAL_POR |-> !OSC_HIGH_FREQ && !CARD_SUPPLY_EN)
    else $error("card powered during hold");
  chk_idle_contacts: assert property (
    !OSC_HIGH_FREQ |-> !CARD_RST && !CARD_CLK_OUT && !CARD_DATA_OE_N
      && !CARD_DATA_OUT && HOST_DATA_OE_N)
    else $error("contacts not quiet while slow");
  chk_supply_switch: assert property (
    $rose(CARD_SUPPLY_EN) |-> $rose(OSC_HIGH_FREQ))
    else $error("supply ramp apart from fast switch");
  chk_osc_slow_end: assert property (
    $fell(OSC_HIGH_FREQ) |-> !CARD_SUPPLY_EN && !$past(CARD_SUPPLY_EN, 2))
    else $error("slow mode before supply off");
  chk_data_high_at: assert property (
    $rose(CARD_DATA_OUT) && !seen_r && OSC_HIGH_FREQ |->
      act_r >= DATA_AT - HF_DIV - 4 && act_r <= DATA_AT + HF_DIV + 4)
    else $error("card data high at wrong time");
  chk_rst_after: assert property (
    $rose(CARD_RST) |-> seen_r && act_r >= RST_AT - HF_DIV - 4)
    else $error("card reset enabled early");
  chk_rst_drop: assert property (
    $rose(CARD_POWER_CMD_N) && OSC_HIGH_FREQ |-> ##[1:20] !CARD_RST)
    else $error("card reset not lowered");
  chk_clk_stop: assert property (
    $rose(CARD_POWER_CMD_N) && OSC_HIGH_FREQ |-> ##80 !CARD_CLK_OUT[*8])
    else $error("card clock not stopped low");
  chk_data_low: assert property (
    $rose(CARD_POWER_CMD_N) && OSC_HIGH_FREQ |->
      ##150 !CARD_DATA_OUT && !CARD_DATA_OE_N)
    else $error("card data not pulled low");
  chk_supply_off: assert property (
    $rose(CARD_POWER_CMD_N) && CARD_SUPPLY_EN |->
      ##180 CARD_SUPPLY_EN ##[10:35] !CARD_SUPPLY_EN)
    else $error("card supply not switched off");
  chk_fault_drop: assert property (
    $rose(OVERHEAT) && OSC_HIGH_FREQ |-> ##[1:6] !CARD_FAULT_STATUS)
    else $error("status kept high on fault");
  chk_removal: assert property (
    $fell(CARD_PRESENT_SWITCH) && !INTERNAL_POR |-> ##[1:6] !CARD_FAULT_STATUS)
    else $error("status kept high on removal");
  chk_debounce: assert property (
    $rose(CARD_FAULT_STATUS) |->
      CARD_PRESENT_SWITCH && $past(CARD_PRESENT_SWITCH, 8))
    else $error("status rose without debounce");
  chk_relay_copy: assert property (
    !HOST_DATA_OE_N && !HOST_DATA_OUT |-> !$past(CARD_DATA_IN, 8))
    else $error("host driven low without card master");
endmodule

// File: sim/tb_top.sv
// self-checking bench for the smartcard session sequencer
`timescale 1ns/10ps
module tb_top;
  reg        CORE_CLK = 1'b0;
  reg        ARST_N = 1'b0;
  reg        CARD_POWER_CMD_N = 1'b1;
  reg        HOST_RESET_IN = 1'b1;
  reg        VCC_SEL_5V = 1'b1;
  reg        CARD_PRESENT_SWITCH = 1'b0;
  reg        SUPPLY_OVERCURRENT = 1'b0;
  reg  [2:0] SUPPLY_LOW = 3'h0;
  reg        OVERHEAT = 1'b0;
  reg        host_pull = 1'b0;
  reg        card_pull = 1'b0;
  wire       HOST_CLK_IN, CARD_SUPPLY_LOW, HOST_DATA_IN, CARD_DATA_IN;
  wire       CARD_FAULT_STATUS, OSC_HIGH_FREQ, INTERNAL_POR, CARD_SUPPLY_EN;
  wire       CARD_SUPPLY_5V, CARD_RST, CARD_CLK_OUT, HOST_DATA_OUT;
  wire       HOST_DATA_OE_N, CARD_DATA_OUT, CARD_DATA_OE_N;
  integer    bad_count = 0;
  integer    n_tests = 0;
  integer    n;
  integer    k;
  integer    clk_cnt = 0;
  integer    c0;
  smartcard_session_sequencer #(.LF_DIV(4), .HF_DIV(2), .POR_HOLD(4),
    .DEBOUNCE(4), .WAKE(4)) smartcard_session_sequencer_i (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .CARD_POWER_CMD_N(CARD_POWER_CMD_N), .HOST_RESET_IN(HOST_RESET_IN),
    .HOST_CLK_IN(HOST_CLK_IN), .VCC_SEL_5V(VCC_SEL_5V),
    .CARD_FAULT_STATUS(CARD_FAULT_STATUS), .OSC_HIGH_FREQ(OSC_HIGH_FREQ),
    .INTERNAL_POR(INTERNAL_POR), .CARD_PRESENT_SWITCH(CARD_PRESENT_SWITCH),
    .SUPPLY_OVERCURRENT(SUPPLY_OVERCURRENT), .SUPPLY_LOW(SUPPLY_LOW),
    .OVERHEAT(OVERHEAT), .CARD_SUPPLY_LOW(CARD_SUPPLY_LOW),
    .CARD_SUPPLY_EN(CARD_SUPPLY_EN), .CARD_SUPPLY_5V(CARD_SUPPLY_5V),
    .CARD_RST(CARD_RST), .CARD_CLK_OUT(CARD_CLK_OUT),
    .HOST_DATA_IN(HOST_DATA_IN), .HOST_DATA_OUT(HOST_DATA_OUT),
    .HOST_DATA_OE_N(HOST_DATA_OE_N), .CARD_DATA_IN(CARD_DATA_IN),
    .CARD_DATA_OUT(CARD_DATA_OUT), .CARD_DATA_OE_N(CARD_DATA_OE_N));
  sc_partner sc_partner_i (.clk(CORE_CLK), .supply_en(CARD_SUPPLY_EN),
    .host_oe_n(HOST_DATA_OE_N), .host_out(HOST_DATA_OUT),
    .card_oe_n(CARD_DATA_OE_N), .card_out(CARD_DATA_OUT),
    .host_pull(host_pull), .card_pull(card_pull), .host_line(HOST_DATA_IN),
    .card_line(CARD_DATA_IN), .card_supply_low(CARD_SUPPLY_LOW),
    .ext_clk(HOST_CLK_IN));
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CARD_CLK_OUT) clk_cnt = clk_cnt + 1;
  task chk(input [8*8-1:0] what, input logic [15:0] seen, exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  function logic sig(input [2:0] s);
    case (s)
      3'h0: sig = OSC_HIGH_FREQ;
      3'h1: sig = INTERNAL_POR;
      3'h2: sig = CARD_FAULT_STATUS;
      3'h3: sig = CARD_DATA_IN;
      3'h4: sig = HOST_DATA_IN;
      3'h5: sig = CARD_RST;
      3'h6: sig = CARD_DATA_OUT & ~CARD_DATA_OE_N;
      default: sig = CARD_DATA_OE_N;
    endcase
  endfunction
  // bounded wait on one watched output; n holds the cycles spent
  task wt(input [2:0] s, input logic v, input integer lim);
    begin
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
        @(negedge CORE_CLK);
        n = n + 1;
      end
    end
  endtask
  task t_reset;
    begin
      repeat (10) @(negedge CORE_CLK);
      chk("por", INTERNAL_POR, 1);
      chk("hostoe", HOST_DATA_OE_N, 1);
      chk("cdata", {CARD_DATA_OE_N, CARD_DATA_OUT}, 0);
      ARST_N = 1'b1;
      wt(1, 0, 200);
      chk("hold", n >= 16 && n < 200, 1);
      chk("slow", OSC_HIGH_FREQ, 0);
    end
  endtask
  task t_insert;
    begin
      CARD_PRESENT_SWITCH = 1'b1;
      wt(2, 1, 100);
      chk("deb", n >= 16 && n < 100, 1);
    end
  endtask
  task t_dip;
    begin
      SUPPLY_LOW = 3'h1;
      wt(1, 1, 10);
      chk("dip", n < 10, 1);
      SUPPLY_LOW = 3'h0;
      chk("dipst", CARD_FAULT_STATUS, 1);
      wt(1, 0, 200);
    end
  endtask
  task t_act;
    begin
      c0 = clk_cnt;
      CARD_POWER_CMD_N = 1'b0;
      wt(0, 1, 100);
      chk("wake", n >= 16 && n <= 26, 1);
      chk("supen", CARD_SUPPLY_EN, 1);
      chk("sup5v", CARD_SUPPLY_5V, VCC_SEL_5V);
      wt(6, 1, 1200);
      chk("dhigh", n >= 1080 && n <= 1096, 1);
      chk("noclk", clk_cnt == c0, 1);
      wt(5, 1, 500);
      chk("rsten", n >= 376 && n <= 392, 1);
      chk("clkon", clk_cnt > c0, 1);
    end
  endtask
  task t_relay;
    begin
      HOST_RESET_IN = 1'b0;
      repeat (6) @(negedge CORE_CLK);
      chk("rstfol", CARD_RST, 0);
      HOST_RESET_IN = 1'b1;
      host_pull = 1'b1;
      wt(3, 0, 60);
      chk("xfer", n >= 20 && n <= 26, 1);
      card_pull = 1'b1;
      repeat (40) @(negedge CORE_CLK);
      chk("slave", HOST_DATA_OE_N, 1);
      card_pull = 1'b0;
      host_pull = 1'b0;
      wt(6, 1, 10);
      chk("pulse", n < 10, 1);
      wt(7, 1, 40);
      chk("pulend", n >= 15 && n < 40, 1);
      repeat (10) @(negedge CORE_CLK);
      card_pull = 1'b1;
      wt(4, 0, 60);
      chk("cmast", n >= 20 && n <= 26, 1);
      card_pull = 1'b0;
      repeat (6) @(negedge CORE_CLK);
      chk("hpulse", {HOST_DATA_OE_N, HOST_DATA_OUT}, 1);
      repeat (34) @(negedge CORE_CLK);
    end
  endtask
  task t_deact;
    begin
      CARD_POWER_CMD_N = 1'b1;
      wt(0, 0, 400);
      chk("dtime", n >= 200 && n < 400, 1);
      chk("dpins", {CARD_RST, CARD_CLK_OUT, CARD_DATA_OE_N, CARD_DATA_OUT,
        CARD_SUPPLY_EN}, 0);
    end
  endtask
  task t_faults;
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        VCC_SEL_5V = k[0];
        t_act;
        SUPPLY_OVERCURRENT = k == 0;
        CARD_PRESENT_SWITCH = k != 1;
        SUPPLY_LOW = k == 2 ? 3'h4 : 3'h0;
        OVERHEAT = k == 3;
        repeat (8) @(negedge CORE_CLK);
        chk("fstat", CARD_FAULT_STATUS, 0);
        wt(0, 0, 400);
        chk("emerg", n >= 150 && n < 400, 1);
        CARD_POWER_CMD_N = 1'b1;
        {SUPPLY_OVERCURRENT, SUPPLY_LOW, OVERHEAT} = 5'h00;
        CARD_PRESENT_SWITCH = 1'b1;
        // command must be seen high before the next session's fall
        repeat (4) @(negedge CORE_CLK);
        wt(1, 0, 200);
        wt(2, 1, 100);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial
  begin
    #400000;
    bad_count = bad_count + 1;
    summarize;
  end
  initial
  begin
    t_reset;
    t_insert;
    t_dip;
    t_act;
    t_relay;
    t_deact;
    t_faults;
    summarize;
  end
endmodule
bind smartcard_session_sequencer sc_seq_checker #(.HF_DIV(HF_DIV))
  sc_seq_checker_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .CARD_POWER_CMD_N(CARD_POWER_CMD_N),
    .CARD_PRESENT_SWITCH(CARD_PRESENT_SWITCH), .OVERHEAT(OVERHEAT),
    .CARD_DATA_IN(CARD_DATA_IN), .CARD_FAULT_STATUS(CARD_FAULT_STATUS),
    .OSC_HIGH_FREQ(OSC_HIGH_FREQ), .INTERNAL_POR(INTERNAL_POR),
    .CARD_SUPPLY_EN(CARD_SUPPLY_EN), .CARD_RST(CARD_RST),
    .CARD_CLK_OUT(CARD_CLK_OUT), .HOST_DATA_OUT(HOST_DATA_OUT),
    .HOST_DATA_OE_N(HOST_DATA_OE_N), .CARD_DATA_OUT(CARD_DATA_OUT),
    .CARD_DATA_OE_N(CARD_DATA_OE_N));
